// ### uwdi_pkg.sv
// package: constants and types for the uart data word interface
package uwdi_pkg;
	// ----------------------------------------------------------------
	// address map (byte addresses; data words alias over 16-word windows, control and status one word each)
	// ----------------------------------------------------------------
	localparam logic [31:0] UWDI_RX_BASE = 32'h00206000;
	localparam logic [31:0] UWDI_TX_BASE = 32'h00206040;
	localparam logic [31:0] UWDI_CTRL_ADDR = 32'h00206080;
	localparam logic [31:0] UWDI_STAT_ADDR = 32'h00206084;
	// each data window spans 16 words, so bits 5..2 pick the alias
	localparam int UWDI_WIN_LSB = 6;

	// ----------------------------------------------------------------
	// receive word field positions
	// ----------------------------------------------------------------
	localparam int UWDI_VALID_BIT = 15;
	localparam int UWDI_ERR_BIT = 14;
	localparam int UWDI_OVR_BIT = 13;
	localparam int UWDI_FRM_BIT = 12;
	localparam int UWDI_BRK_BIT = 11;
	localparam int UWDI_PRR_BIT = 10;
	localparam int UWDI_MSB_BIT = 7;

	// ----------------------------------------------------------------
	// control and status fields
	// ----------------------------------------------------------------
	localparam int UWDI_CTRL_PAR_EN = 0;
	localparam int UWDI_CTRL_PAR_ODD = 1;
	localparam int UWDI_CTRL_EIGHT = 2;
	localparam logic [2:0] UWDI_CTRL_RESET = 3'h4;
	localparam int UWDI_STAT_SPACE = 0;
	localparam int UWDI_STAT_LEVEL_LSB = 8;

	// ----------------------------------------------------------------
	// sizes and timing
	// ----------------------------------------------------------------
	localparam int UWDI_FIFO_DEPTH = 32;
	localparam int UWDI_CLK_HZ = 50000000;
	localparam int UWDI_BAUD = 115200;
	localparam int UWDI_BIT_CYCLES = UWDI_CLK_HZ / UWDI_BAUD;

	// one stored receive character with its flags
	typedef struct packed
	{
		logic ovr;
		logic frm;
		logic break_detect_flag;
		logic prr;
		logic [7:0] data;
	} uwdi_rx_entry_type;

	// character format chosen by software
	typedef struct packed
	{
		logic eight_bit;
		logic par_odd;
		logic par_en;
	} uwdi_ctrl_type;
endpackage

// ### uwdi_tx.sv
// module: serial transmit shifter for one character frame
module uwdi_tx #(
	parameter int BIT_CYCLES = uwdi_pkg::UWDI_BIT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// character request
	input wire logic start,
	input wire logic [7:0] data,
	input wire uwdi_pkg::uwdi_ctrl_type cfg,
	// line side
	output logic txd,
	output logic busy
);
	import uwdi_pkg::*;

	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} uwdi_tx_state_type;

	uwdi_tx_state_type state_reg;
	logic [15:0] cnt_reg;
	logic [2:0] bit_reg;
	logic [7:0] data_reg;
	logic par_reg;
	logic txd_reg;
	logic last_bit;

	generate
		if (BIT_CYCLES < 4 || BIT_CYCLES > 65535)
		begin : g_bad
			$error("uwdi_tx: BIT_CYCLES out of range");
		end
	endgenerate

	// seven or eight data bits per frame
	assign last_bit = bit_reg == (cfg.eight_bit ? 3'h7 : 3'h6);
	assign txd = txd_reg;
	assign busy = (state_reg != TX_IDLE);

	// ----------------------------------------------------------------
	// frame sequencer: start, data lsb first, optional parity, stop
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_reg <= TX_IDLE;
			cnt_reg <= 16'h0000;
			bit_reg <= 3'h0;
			data_reg <= 8'h00;
			par_reg <= 1'b0;
			txd_reg <= 1'b1;
		end
		else if (state_reg == TX_IDLE)
		begin
			if (start)
			begin
				state_reg <= TX_START;
				data_reg <= data;
				par_reg <= (^data) ^ cfg.par_odd;
				cnt_reg <= 16'(BIT_CYCLES - 1);
				txd_reg <= 1'b0;
			end
		end
		else if (cnt_reg != 16'h0000)
			cnt_reg <= cnt_reg - 16'h0001;
		else
		begin
			cnt_reg <= 16'(BIT_CYCLES - 1);
			case (state_reg)
				TX_START:
				begin
					state_reg <= TX_DATA;
					bit_reg <= 3'h0;
					txd_reg <= data_reg[0]; // see [R13]
				end
				TX_DATA:
				begin
					if (last_bit)
					begin
						state_reg <= cfg.par_en ? TX_PARITY : TX_STOP;
						txd_reg <= cfg.par_en ? par_reg : 1'b1;
					end
					else
					begin
						bit_reg <= bit_reg + 3'h1;
						txd_reg <= data_reg[bit_reg + 3'h1]; // see [R13]
					end
				end
				TX_PARITY:
				begin
					state_reg <= TX_STOP;
					txd_reg <= 1'b1;
				end
				default:
				begin
					state_reg <= TX_IDLE;
					txd_reg <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_lsb_first_order: assert property (@(posedge clk) disable iff (!nrst) // see [R13]
		state_reg == TX_DATA |-> txd_reg == data_reg[bit_reg])
		else $error("transmit bit does not match lsb-first order");
endmodule

// ### uwdi_top.sv
// module: apb character data interface with receive queue and transmitter
// Functional notes
// [R1] framing flag at bit 12 set when stop bit missing, else clear.
// [R2] break flag at bit 11 when all data bits and stop are zero.
// [R3] a break character always also carries the framing flag.
// [R4] with odd parity, a break character also carries the parity flag.
// [R5] parity flag at bit 10 set when the parity check fails.
// [R6] parity flag reads zero while parity checking is off.
// [R7] status flags travel with each queued character and describe it.
// [R8] receive bits 9-8 and transmit bits 31-8 read zero.
// [R9] character in bits 7-0; bit 7 reads zero in seven-bit mode.
// [R10] transmit word is write-only and reads as zero.
// [R11] transmit word decoded at 16 consecutive word addresses.
// [R12] seven-bit mode drops written bit 7; eight-bit mode sends all.
// [R13] characters are shifted out least significant bit first.
// [R14] each transmit write enqueues exactly one character.
// [R15] software writes only while the transmitter-space flag is high.
// [R16] valid flag at bit 15 is one for fresh data, zero when empty.
// [R17] error flag at bit 14 is the or of the four error flags.
// [R18] 32nd stored character gets overrun flag; later ones are dropped.
// [R19] receive word decoded at 16 consecutive word addresses.
// [R20] a valid receive read removes that entry from the queue.
//
// Local design decision: the APB interface to the registers.
module uwdi_top #(
	parameter int DEPTH = uwdi_pkg::UWDI_FIFO_DEPTH,
	parameter int BIT_CYCLES = uwdi_pkg::UWDI_BIT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial line
	input wire logic rxd,
	output logic txd
);
	import uwdi_pkg::*;

	localparam int CW = $clog2(DEPTH) + 1;
	localparam int PW = $clog2(DEPTH);

	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} uwdi_rx_state_type;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH > 64)
		begin : g_bad_depth
			$error("uwdi_top: DEPTH must be a power of two from 2 to 64");
		end
		if (BIT_CYCLES < 4 || BIT_CYCLES > 65535)
		begin : g_bad_bit
			$error("uwdi_top: BIT_CYCLES out of range");
		end
	endgenerate

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic setup, access;
	logic hit_rx, hit_tx, hit_ctrl, hit_stat, hit_any;

	assign setup = psel && !penable;
	assign access = psel && penable;
	// address bits 5..2 are ignored inside each window for burst aliases
	assign hit_rx = paddr[31:UWDI_WIN_LSB] == UWDI_RX_BASE[31:UWDI_WIN_LSB]; // see [R19]
	assign hit_tx = paddr[31:UWDI_WIN_LSB] == UWDI_TX_BASE[31:UWDI_WIN_LSB]; // see [R11]
	assign hit_ctrl = paddr == UWDI_CTRL_ADDR;
	assign hit_stat = paddr == UWDI_STAT_ADDR;
	assign hit_any = hit_rx || hit_tx || hit_ctrl || hit_stat;
	// zero wait states; error for unmapped or writes to read-only words
	assign pready = 1'b1;
	assign pslverr = access && (!hit_any || (pwrite && (hit_rx || hit_stat)));

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	uwdi_ctrl_type cfg_reg;

	// character format steers both receiver and transmitter
	always_ff @(posedge clk)
	begin
		if (!nrst)
			cfg_reg <= UWDI_CTRL_RESET;
		else if (access && pwrite && hit_ctrl)
			cfg_reg <= {pwdata[UWDI_CTRL_EIGHT], pwdata[UWDI_CTRL_PAR_ODD], pwdata[UWDI_CTRL_PAR_EN]};
	end

	// ----------------------------------------------------------------
	// receiver: synchroniser and frame sampler
	// ----------------------------------------------------------------
	logic rxd_meta_reg, rxd_sync_reg;
	uwdi_rx_state_type rx_state_reg;
	logic [15:0] rx_cnt_reg;
	logic [2:0] rx_bit_reg;
	logic [7:0] rx_data_reg;
	logic rx_par_reg;
	logic rx_push, rx_stop, rx_last;

	// two flops before anything looks at the line
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			rxd_meta_reg <= 1'b1;
			rxd_sync_reg <= 1'b1;
		end
		else
		begin
			rxd_meta_reg <= rxd;
			rxd_sync_reg <= rxd_meta_reg;
		end
	end

	assign rx_last = rx_bit_reg == (cfg_reg.eight_bit ? 3'h7 : 3'h6);
	assign rx_push = rx_state_reg == RX_STOP && rx_cnt_reg == 16'h0000;
	assign rx_stop = rxd_sync_reg;

	// samples each bit at its centre; start checked at half a bit
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg <= 16'h0000;
			rx_bit_reg <= 3'h0;
			rx_data_reg <= 8'h00;
			rx_par_reg <= 1'b0;
		end
		else if (rx_state_reg == RX_IDLE)
		begin
			if (!rxd_sync_reg)
			begin
				rx_state_reg <= RX_START;
				rx_cnt_reg <= 16'(BIT_CYCLES / 2);
				rx_data_reg <= 8'h00;
				rx_bit_reg <= 3'h0;
			end
		end
		else if (rx_cnt_reg != 16'h0000)
			rx_cnt_reg <= rx_cnt_reg - 16'h0001;
		else
		begin
			rx_cnt_reg <= 16'(BIT_CYCLES - 1);
			case (rx_state_reg)
				RX_START:
					rx_state_reg <= rxd_sync_reg ? RX_IDLE : RX_DATA;
				RX_DATA:
				begin
					rx_data_reg[rx_bit_reg] <= rxd_sync_reg;
					rx_bit_reg <= rx_bit_reg + 3'h1;
					if (rx_last)
						rx_state_reg <= cfg_reg.par_en ? RX_PARITY : RX_STOP;
				end
				RX_PARITY:
				begin
					rx_par_reg <= rxd_sync_reg;
					rx_state_reg <= RX_STOP;
				end
				default:
					rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// flags of the character being completed
	// ----------------------------------------------------------------
	uwdi_rx_entry_type rx_entry;
	logic [CW-1:0] count_reg;

	always_comb
	begin
		rx_entry.data = rx_data_reg;
		rx_entry.break_detect_flag = (rx_data_reg == 8'h00) && !rx_stop; // see [R2]
		rx_entry.frm = !rx_stop || rx_entry.break_detect_flag; // see [R1] [R3]
		// even: error when data xor parity is one; odd: when it is zero
		rx_entry.prr = cfg_reg.par_en
			&& (((^rx_data_reg) ^ rx_par_reg ^ cfg_reg.par_odd) || (rx_entry.break_detect_flag && cfg_reg.par_odd)); // see [R5] [R4]
		rx_entry.ovr = count_reg == CW'(DEPTH - 1); // see [R18]
	end

	// ----------------------------------------------------------------
	// receive queue
	// ----------------------------------------------------------------
	uwdi_rx_entry_type mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic push_ok, pop;
	logic [31:0] rd_val_reg;

	// a full queue refuses new characters until software reads
	assign push_ok = rx_push && count_reg != CW'(DEPTH); // see [R18]
	// pop only when the latched answer said the entry was valid
	assign pop = access && !pwrite && hit_rx && rd_val_reg[UWDI_VALID_BIT]; // see [R20]

	// storage keeps flags beside each character
	always_ff @(posedge clk)
	begin
		if (push_ok)
			mem_reg[wr_ptr_reg] <= rx_entry; // see [R7]
	end

	// pointers and fill level
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push_ok)
				wr_ptr_reg <= wr_ptr_reg + PW'(1);
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + PW'(1);
			if (push_ok && !pop)
				count_reg <= count_reg + CW'(1);
			else if (pop && !push_ok)
				count_reg <= count_reg - CW'(1);
		end
	end

	// ----------------------------------------------------------------
	// read word assembly
	// ----------------------------------------------------------------
	uwdi_rx_entry_type head, last_reg;
	logic [31:0] rx_word;
	logic tx_full_reg;

	assign head = count_reg != '0 ? mem_reg[rd_ptr_reg] : last_reg;

	// data and flags gated by the current character format
	always_comb
	begin
		rx_word = 32'h00000000; // see [R8]
		rx_word[7:0] = head.data;
		if (!cfg_reg.eight_bit)
			rx_word[UWDI_MSB_BIT] = 1'b0; // see [R9]
		rx_word[UWDI_OVR_BIT] = head.ovr;
		rx_word[UWDI_FRM_BIT] = head.frm;
		rx_word[UWDI_BRK_BIT] = head.break_detect_flag;
		rx_word[UWDI_PRR_BIT] = head.prr && cfg_reg.par_en; // see [R6]
		rx_word[UWDI_ERR_BIT] = head.ovr || head.frm || head.break_detect_flag || rx_word[UWDI_PRR_BIT]; // see [R17]
		rx_word[UWDI_VALID_BIT] = count_reg != '0; // see [R16]
	end

	// stale data repeats the last character returned
	always_ff @(posedge clk)
	begin
		if (!nrst)
			last_reg <= '0;
		else if (pop)
			last_reg <= mem_reg[rd_ptr_reg];
	end

	// answer latched in the setup cycle so prdata comes from a flop
	always_ff @(posedge clk)
	begin
		if (!nrst)
			rd_val_reg <= 32'h00000000;
		else if (setup)
		begin
			rd_val_reg <= 32'h00000000; // see [R10]
			if (!pwrite && hit_rx)
				rd_val_reg <= rx_word;
			else if (!pwrite && hit_ctrl)
				rd_val_reg <= {29'h0, cfg_reg};
			else if (!pwrite && hit_stat)
			begin
				rd_val_reg[UWDI_STAT_SPACE] <= !tx_full_reg;
				rd_val_reg[UWDI_STAT_LEVEL_LSB +: CW] <= count_reg;
			end
		end
	end

	assign prdata = rd_val_reg;

	// ----------------------------------------------------------------
	// transmit holding stage
	// ----------------------------------------------------------------
	logic [7:0] tx_hold_reg, tx_char;
	logic tx_busy, tx_start;

	// seven-bit mode drops the written top bit
	assign tx_char = {pwdata[UWDI_MSB_BIT] && cfg_reg.eight_bit, pwdata[6:0]}; // see [R12]
	assign tx_start = tx_full_reg && !tx_busy;

	// a write while full overwrites the waiting character; software
	// must watch the space flag to avoid that
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			tx_full_reg <= 1'b0;
			tx_hold_reg <= 8'h00;
		end
		else if (access && pwrite && hit_tx)
		begin
			tx_full_reg <= 1'b1; // see [R14] [R15]
			tx_hold_reg <= tx_char;
		end
		else if (tx_start)
			tx_full_reg <= 1'b0;
	end

	uwdi_tx #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_tx (
		.clk(clk),
		.nrst(nrst),
		.start(tx_start),
		.data(tx_hold_reg),
		.cfg(cfg_reg),
		.txd(txd),
		.busy(tx_busy)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_rx_read;
		psel && !penable && !pwrite && hit_rx ##1 psel && penable;
	endsequence

	a_frame_flag_set: assert property (@(posedge clk) disable iff (!nrst) // see [R1]
		push_ok |=> mem_reg[$past(wr_ptr_reg)].frm == $past(!rx_stop))
		else $error("framing flag does not follow stop bit");
	a_break_implies_frame: assert property (@(posedge clk) disable iff (!nrst) // see [R3]
		s_rx_read |-> !prdata[UWDI_BRK_BIT] || prdata[UWDI_FRM_BIT])
		else $error("break without framing flag");
	a_break_odd_parity: assert property (@(posedge clk) disable iff (!nrst) // see [R4]
		push_ok && rx_entry.break_detect_flag && cfg_reg.par_en && cfg_reg.par_odd |=> mem_reg[$past(wr_ptr_reg)].prr)
		else $error("break with odd parity lacks parity flag");
	a_parity_off_zero: assert property (@(posedge clk) disable iff (!nrst) // see [R6]
		s_rx_read ##0 !cfg_reg.par_en |-> !prdata[UWDI_PRR_BIT])
		else $error("parity flag set while parity disabled");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst) // see [R8]
		s_rx_read |-> prdata[9:8] == 2'h0 && prdata[31:16] == 16'h0000)
		else $error("reserved receive bits not zero");
	a_tx_read_zero: assert property (@(posedge clk) disable iff (!nrst) // see [R10]
		access && !pwrite && hit_tx |-> prdata == 32'h00000000)
		else $error("transmit word read not zero");
	a_tx_enqueue_one: assert property (@(posedge clk) disable iff (!nrst) // see [R14]
		access && pwrite && hit_tx |=> tx_full_reg && tx_hold_reg == $past(tx_char))
		else $error("transmit write not enqueued");
	a_empty_invalid: assert property (@(posedge clk) disable iff (!nrst) // see [R16]
		setup && !pwrite && hit_rx && count_reg == '0 |=> !prdata[UWDI_VALID_BIT])
		else $error("empty queue returned valid flag");
	a_err_summary: assert property (@(posedge clk) disable iff (!nrst) // see [R17]
		s_rx_read |-> prdata[UWDI_ERR_BIT] == |prdata[UWDI_OVR_BIT:UWDI_PRR_BIT])
		else $error("summary error flag mismatch");
	a_overrun_mark: assert property (@(posedge clk) disable iff (!nrst) // see [R18]
		push_ok && count_reg == CW'(DEPTH - 1) |=> mem_reg[$past(wr_ptr_reg)].ovr)
		else $error("last queue slot not marked overrun");
	a_full_drop: assert property (@(posedge clk) disable iff (!nrst) // see [R18]
		rx_push && count_reg == CW'(DEPTH) && !pop |=> count_reg == CW'(DEPTH) && $stable(wr_ptr_reg))
		else $error("full queue accepted a character");
	a_pop_advance: assert property (@(posedge clk) disable iff (!nrst) // see [R20]
		s_rx_read ##0 prdata[UWDI_VALID_BIT] |=> rd_ptr_reg == $past(rd_ptr_reg) + PW'(1))
		else $error("valid read did not remove entry");
endmodule

// ### uwdi_line_model.sv
// partner model: remote serial transmitter and receiver on the line
module uwdi_line_model #(
	parameter int BIT_CYCLES = 8
) (
	// clock
	input wire logic clk,
	// serial line
	output logic rxd,
	input wire logic txd
);
	timeunit 1ns;
	timeprecision 100ps;

	// line rests high between frames, like a pulled-up wire
	initial rxd = 1'b1;

	// ----------------------------------------------------------------
	// frame sender and frame catcher
	// ----------------------------------------------------------------
	// one frame; par below zero leaves out the parity bit, stop low fakes a lost stop
	task automatic send(input logic [7:0] d, input int nb, input int par, input logic stop);
		int i;
		@(posedge clk);
		rxd <= 1'b0;
		repeat (BIT_CYCLES) @(posedge clk);
		for (i = 0; i < nb; i++)
		begin
			rxd <= d[i];
			repeat (BIT_CYCLES) @(posedge clk);
		end
		if (par >= 0)
		begin
			rxd <= par[0];
			repeat (BIT_CYCLES) @(posedge clk);
		end
		rxd <= stop;
		repeat (BIT_CYCLES) @(posedge clk);
		rxd <= 1'b1;
		repeat (BIT_CYCLES) @(posedge clk);
	endtask

	// samples mid-bit; ok stays low when no start bit shows within limit cycles
	task automatic capture(input int nb, input int limit, output logic [8:0] v, output logic ok);
		int i;
		v = 9'h0;
		ok = 1'b0;
		for (i = 0; i < limit && !ok; i++)
		begin
			@(posedge clk);
			ok = (txd === 1'b0);
		end
		if (ok)
		begin
			repeat (BIT_CYCLES / 2) @(posedge clk);
			for (i = 0; i <= nb; i++)
			begin
				repeat (BIT_CYCLES) @(posedge clk);
				v[(i == nb) ? 8 : i] = txd;
			end
		end
	endtask
endmodule

// ### uart_data_word_interface_test.sv
// testbench: register-level checks of the uart data word interface
module uart_data_word_interface_test;
	timeunit 1ns;
	timeprecision 100ps;
	import uwdi_pkg::*;

	// short bit time and queue keep the run brief
	localparam int BITS = 8;
	localparam int DEPTH = 4;
	localparam int FRAME = BITS * 12;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rxd;
	logic txd;
	int errors = 0;
	int checked = 0;
	logic [31:0] rd;
	logic er;
	logic [8:0] fr;
	logic ok;
	int i;

	// 50 MHz clock
	always #10 clk = ~clk;

	uwdi_top #(.DEPTH(DEPTH), .BIT_CYCLES(BITS)) dut_u (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));
	uwdi_line_model #(.BIT_CYCLES(BITS)) line_u (.clk(clk), .rxd(rxd), .txd(txd));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("counts: %0d checked, %0d errors", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			errors++;
			$display("mismatch at %0t: apb answer timed out", $time);
			conclude();
		end
	endtask

	task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0, rd, er);
		chk(rd, exp, what);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, er);
	endtask

	// expected receive word; error summary derived from the four flags
	function automatic logic [31:0] rxw(input logic v, input logic o, input logic f, input logic b,
		input logic p, input logic [7:0] d);
		rxw = {16'h0, v, o | f | b | p, o, f, b, p, 2'h0, d};
	endfunction

	// a write while the holding stage is full would overwrite, so poll first
	task automatic txc(input logic [31:0] a, input logic [7:0] d);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, UWDI_STAT_ADDR, 32'h0, rd, er);
			n++;
		end
		while (rd[UWDI_STAT_SPACE] !== 1'b1 && n < 100);
		if (rd[UWDI_STAT_SPACE] !== 1'b1)
		begin
			errors++;
			$display("mismatch at %0t: transmit space never came", $time);
			conclude();
		end
		wr(a, {24'h0, d});
	endtask

	task automatic grab(input int nb, input logic [8:0] exp, input string what);
		line_u.capture(nb, FRAME * 4, fr, ok);
		if (!ok)
		begin
			errors++;
			$display("mismatch at %0t: no transmit frame seen", $time);
			conclude();
		end
		chk({23'h0, fr}, {23'h0, exp}, what);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rdc(UWDI_CTRL_ADDR, {29'h0, UWDI_CTRL_RESET}, "control reset");
		apb(1'b0, UWDI_RX_BASE, 32'h0, rd, er);
		chk({31'h0, rd[UWDI_VALID_BIT]}, 32'h0, "empty valid");
		rdc(UWDI_TX_BASE + 32'h4, 32'h0, "tx reads zero");
		apb(1'b0, 32'h00206100, 32'h0, rd, er);
		chk({31'h0, er}, 32'h1, "unmapped error");
		wr(UWDI_RX_BASE, 32'h5a);
		chk({31'h0, er}, 32'h1, "rx write refused");
		$display("test reset_and_decode done");

		// clean, framing and break characters
		line_u.send(8'ha5, 8, -1, 1'b1);
		rdc(UWDI_RX_BASE + 32'h3c, rxw(1, 0, 0, 0, 0, 8'ha5), "clean char");
		rdc(UWDI_RX_BASE, rxw(0, 0, 0, 0, 0, 8'ha5), "stale read");
		line_u.send(8'h3c, 8, -1, 1'b0);
		rdc(UWDI_RX_BASE, rxw(1, 0, 1, 0, 0, 8'h3c), "framing");
		wr(UWDI_CTRL_ADDR, 32'h7);
		line_u.send(8'h00, 8, 1, 1'b0);
		rdc(UWDI_RX_BASE, rxw(1, 0, 1, 1, 1, 8'h00), "break odd");
		$display("test flags done");

		// even parity: a bad character queued ahead of a good one
		wr(UWDI_CTRL_ADDR, 32'h5);
		line_u.send(8'h01, 8, 0, 1'b1);
		line_u.send(8'h03, 8, 0, 1'b1);
		rdc(UWDI_RX_BASE, rxw(1, 0, 0, 0, 1, 8'h01), "parity bad");
		rdc(UWDI_RX_BASE, rxw(1, 0, 0, 0, 0, 8'h03), "parity good");
		line_u.send(8'h01, 8, 0, 1'b1);
		wr(UWDI_CTRL_ADDR, 32'h4);
		rdc(UWDI_RX_BASE, rxw(1, 0, 0, 0, 0, 8'h01), "parity off");
		line_u.send(8'hff, 8, -1, 1'b1);
		wr(UWDI_CTRL_ADDR, 32'h0);
		rdc(UWDI_RX_BASE, rxw(1, 0, 0, 0, 0, 8'h7f), "seven bit read");
		line_u.send(8'h55, 7, -1, 1'b1);
		rdc(UWDI_RX_BASE, rxw(1, 0, 0, 0, 0, 8'h55), "seven bit frame");
		$display("test parity_and_width done");

		// transmit in both widths, at the first and last alias
		txc(UWDI_TX_BASE, 8'hff);
		grab(7, 9'h17f, "seven bit tx");
		wr(UWDI_CTRL_ADDR, 32'h4);
		txc(UWDI_TX_BASE + 32'h3c, 8'ha5);
		grab(8, 9'h1a5, "eight bit tx");
		line_u.capture(8, FRAME * 2, fr, ok);
		chk({31'h0, ok}, 32'h0, "single frame");
		// odd parity: the ninth sample lands on the parity bit
		wr(UWDI_CTRL_ADDR, 32'h7);
		txc(UWDI_TX_BASE + 32'h4, 8'h01);
		grab(8, 9'h001, "odd parity tx");
		wr(UWDI_CTRL_ADDR, 32'h4);
		$display("test transmit done");

		// one more character than the queue holds
		for (i = 0; i <= DEPTH; i++)
			line_u.send(8'(i + 16), 8, -1, 1'b1);
		for (i = 0; i < DEPTH; i++)
			rdc(UWDI_RX_BASE, rxw(1, i == DEPTH - 1, 0, 0, 0, 8'(i + 16)), "queue entry");
		rdc(UWDI_RX_BASE, rxw(0, 1, 0, 0, 0, 8'(DEPTH + 15)), "dropped char");
		$display("test overrun done");
		conclude();
	end
endmodule
